// ==== src/seb_status_bank.sv ====
// Status and error register bank with an APB slave and one interrupt.
// Assumes the core delivers event pulses synchronous to ref_clk and
// that expInstalled is stable at and after reset release.
//
// Notes on behaviour
// - Ready low while message operation runs.
// - Result flag 0 normal, 1 on error.
// - Abnormal end stores error code word.
// - Self-diagnosis error code stored on detect.
// - Module I/O error sets extension bit.
// - Module error sets position bit, 1=error.
// - Inconsistent setting stores its register number.
// - Port four errors as 16 bits.
// - Ports two/three overflow, parity, overrun bits.
// - Expansion install change sets mismatch bit.
//
// The APB interface to the registers and the address map were decided locally.
module seb_status_bank
  import seb_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire seb_evt_t          evt,
  input  wire logic [15:0]       expInstalled,
  output logic                   msgReady,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_SELF_DIAG, ADDR_MODULE_IO_ERR, ADDR_MODULE_ERR, ADDR_SETTING_NUM,
      ADDR_PORT4_ERR, ADDR_PORT23_ERR, ADDR_EXP_MISMATCH, ADDR_MSG_STATUS,
      ADDR_MSG_RESULT, ADDR_IRQ_STATUS, ADDR_IRQ_MASK: isMapped = 1'b1;
      default:                                       isMapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] readWord(input seb_state_t s,
                                           input logic [ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      ADDR_SELF_DIAG:     w[15:0] = s.selfDiagCode;
      ADDR_MODULE_IO_ERR: w[15:0] = s.moduleIoErr;
      ADDR_MODULE_ERR:    w[15:0] = s.moduleErr;
      ADDR_SETTING_NUM:   w[15:0] = s.settingNum;
      ADDR_PORT4_ERR:     w[15:0] = s.port4Err;
      ADDR_PORT23_ERR:    w[15:0] = s.port23Err;
      ADDR_EXP_MISMATCH:  w[15:0] = s.expMismatch;
      ADDR_MSG_STATUS: begin
        w[MSG_READY_BIT]  = (s.op == SEB_IDLE);
        w[MSG_RESULT_BIT] = s.resultFlag;
      end
      ADDR_MSG_RESULT:    w[15:0] = s.resultCode;
      ADDR_IRQ_STATUS:    w[IRQ_W-1:0] = s.irqStatus;
      ADDR_IRQ_MASK:      w[IRQ_W-1:0] = s.irqMask;
      default:            w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  seb_state_t  st;
  seb_state_t  next_st;
  logic        setupRd;
  logic        accWr;
  logic [7:0]  events;
  logic [15:0] diffBits;

  // Read data is sampled in the setup cycle so prdata comes from a flop
  // while the slave still answers with zero wait states.
  assign setupRd  = psel && !penable && !pwrite;
  assign accWr    = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !isMapped(paddr);
  assign prdata   = st.prdata;
  assign msgReady = (st.op == SEB_IDLE);
  assign irq      = |(st.irqStatus & st.irqMask);
  assign diffBits = st.baselineValid ? (expInstalled ^ st.expBaseline) : RST_WORD;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    events  = 8'h00;

    unique case (st.op)
      SEB_IDLE: begin
        if (evt.opStart) begin
          next_st.op = SEB_BUSY;
        end
      end
      SEB_BUSY: begin
        if (evt.opEnd) begin
          next_st.op         = evt.opStart ? SEB_BUSY : SEB_IDLE;
          next_st.resultFlag = evt.opError;
          events[EV_MSG_DONE] = 1'b1;
          if (evt.opError) begin
            next_st.resultCode = evt.opErrCode;
          end
        end
      end
    endcase

    if (evt.diagValid) begin
      next_st.selfDiagCode = evt.diagCode;
      events[EV_SELF_DIAG] = 1'b1;
    end
    // Extension 1 sits in bit 0, extension 2 in bit 1
    next_st.moduleIoErr[1:0] = st.moduleIoErr[1:0] | evt.moduleIoErr;
    events[EV_MODULE_IO]     = |evt.moduleIoErr;
    next_st.moduleErr[1:0]   = st.moduleErr[1:0] | evt.moduleErr;
    events[EV_MODULE]        = |evt.moduleErr;
    if (evt.settingValid) begin
      next_st.settingNum = evt.settingNum;
      events[EV_SETTING] = 1'b1;
    end
    next_st.port4Err        = st.port4Err | evt.port4Err;
    events[EV_PORT4]        = |evt.port4Err;
    next_st.port23Err[5:0]  = st.port23Err[5:0] | evt.port23Err;
    events[EV_PORT23]       = |evt.port23Err;

    // Baseline taken at the first edge after release, never under reset
    if (!st.baselineValid) begin
      next_st.expBaseline   = expInstalled;
      next_st.baselineValid = 1'b1;
    end
    next_st.expMismatch     = st.expMismatch | diffBits;
    events[EV_EXPANSION]    = |diffBits;

    // Only mask and interrupt status accept writes; set wins over clear
    if (accWr && paddr == ADDR_IRQ_MASK) begin
      next_st.irqMask = pwdata[IRQ_W-1:0];
    end
    next_st.irqStatus = st.irqStatus | events;
    if (accWr && paddr == ADDR_IRQ_STATUS) begin
      next_st.irqStatus = (st.irqStatus & ~pwdata[IRQ_W-1:0]) | events;
    end
    // Writes to the status words fall through here untouched

    if (setupRd) begin
      next_st.prdata = readWord(st, paddr);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st.op            <= SEB_IDLE;
      st.resultFlag    <= 1'b0;
      st.resultCode    <= RST_WORD;
      st.selfDiagCode  <= RST_WORD;
      st.moduleIoErr   <= RST_WORD;
      st.moduleErr     <= RST_WORD;
      st.settingNum    <= RST_WORD;
      st.port4Err      <= RST_WORD;
      st.port23Err     <= RST_WORD;
      st.expBaseline   <= RST_WORD;
      st.baselineValid <= 1'b0;
      st.expMismatch   <= RST_WORD;
      st.irqStatus     <= RST_IRQ;
      st.irqMask       <= RST_IRQ;
      st.prdata        <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_startBusy;
    st.op == SEB_IDLE && evt.opStart |=> !msgReady;
  endproperty
  a_startBusy: assert property (p_startBusy)
    else $error("ready not held low during operation");

  property p_endReady;
    st.op == SEB_BUSY && evt.opEnd && !evt.opStart |=> msgReady;
  endproperty
  a_endReady: assert property (p_endReady)
    else $error("ready not restored at operation end");

  property p_result;
    st.op == SEB_BUSY && evt.opEnd |=> st.resultFlag == $past(evt.opError);
  endproperty
  a_result: assert property (p_result)
    else $error("result flag wrong at operation end");

  property p_resultCode;
    st.op == SEB_BUSY && evt.opEnd && evt.opError
      |=> st.resultCode == $past(evt.opErrCode);
  endproperty
  a_resultCode: assert property (p_resultCode)
    else $error("error code not stored on abnormal end");

  property p_diag;
    evt.diagValid |=> st.selfDiagCode == $past(evt.diagCode);
  endproperty
  a_diag: assert property (p_diag)
    else $error("self diagnosis code not stored");

  property p_modIo;
    evt.moduleIoErr != 2'b00 |=> (st.moduleIoErr[1:0] & $past(evt.moduleIoErr))
                                 == $past(evt.moduleIoErr)
      ##1 (st.moduleIoErr[1:0] & $past(evt.moduleIoErr, 2)) == $past(evt.moduleIoErr, 2);
  endproperty
  a_modIo: assert property (p_modIo)
    else $error("module io error bit not sticky");

  property p_mod;
    evt.moduleErr != 2'b00 |=> (st.moduleErr[1:0] & $past(evt.moduleErr))
                               == $past(evt.moduleErr);
  endproperty
  a_mod: assert property (p_mod)
    else $error("module error bit not set");

  property p_setting;
    evt.settingValid |=> st.settingNum == $past(evt.settingNum);
  endproperty
  a_setting: assert property (p_setting)
    else $error("setting number not stored");

  property p_port4;
    evt.port4Err != 16'h0000 |=> (st.port4Err & $past(evt.port4Err)) == $past(evt.port4Err);
  endproperty
  a_port4: assert property (p_port4)
    else $error("port four error bit not set");

  property p_port23;
    evt.port23Err != 6'h00
      |=> (st.port23Err[5:0] & $past(evt.port23Err)) == $past(evt.port23Err)
          && st.port23Err[15:6] == 10'h000;
  endproperty
  a_port23: assert property (p_port23)
    else $error("unused port two/three bits set");

  property p_exp;
    st.baselineValid && expInstalled != st.expBaseline
      |=> (st.expMismatch & ($past(expInstalled) ^ st.expBaseline))
            == ($past(expInstalled) ^ st.expBaseline) && st.irqStatus[EV_EXPANSION];
  endproperty
  a_exp: assert property (p_exp)
    else $error("expansion change not flagged");

  property p_roWrite;
    accWr && paddr == ADDR_SELF_DIAG && !evt.diagValid |=> $stable(st.selfDiagCode);
  endproperty
  a_roWrite: assert property (p_roWrite)
    else $error("write changed a read only word");

  property p_busyHold;
    st.op == SEB_BUSY && !evt.opEnd |=> !msgReady;
  endproperty
  a_busyHold: assert property (p_busyHold)
    else $error("ready rose while operation still running");

  property p_msgIrq;
    st.op == SEB_BUSY && evt.opEnd |=> st.irqStatus[EV_MSG_DONE];
  endproperty
  a_msgIrq: assert property (p_msgIrq)
    else $error("operation end did not raise its status bit");

  property p_normalEnd;
    st.op == SEB_BUSY && evt.opEnd && !evt.opError |=> $stable(st.resultCode);
  endproperty
  a_normalEnd: assert property (p_normalEnd)
    else $error("error code changed on normal end");

  property p_diagIrq;
    evt.diagValid |=> st.irqStatus[EV_SELF_DIAG];
  endproperty
  a_diagIrq: assert property (p_diagIrq)
    else $error("self diagnosis did not raise its status bit");

  property p_modSticky;
    st.moduleErr != RST_WORD |=> (st.moduleErr & $past(st.moduleErr)) == $past(st.moduleErr);
  endproperty
  a_modSticky: assert property (p_modSticky)
    else $error("module error bit cleared without reset");

  property p_expBaseline;
    st.baselineValid |=> $stable(st.expBaseline);
  endproperty
  a_expBaseline: assert property (p_expBaseline)
    else $error("expansion baseline changed after capture");

  property p_roPort4;
    accWr && paddr == ADDR_PORT4_ERR && evt.port4Err == 16'h0000 |=> $stable(st.port4Err);
  endproperty
  a_roPort4: assert property (p_roPort4)
    else $error("write changed port four error word");

  property p_roModErr;
    accWr && paddr == ADDR_MODULE_ERR && evt.moduleErr == 2'b00 |=> $stable(st.moduleErr);
  endproperty
  a_roModErr: assert property (p_roModErr)
    else $error("write changed module error bitmap");

endmodule // seb_status_bank

// ==== common/seb_pkg.sv ====
// Shared constants and types of the status and error register bank.
// Assumes an APB slave with byte addresses and one aligned 32-bit word per register.
package seb_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W              = 8;
  localparam logic [7:0]  ADDR_SELF_DIAG      = 8'h00;
  localparam logic [7:0]  ADDR_MODULE_IO_ERR  = 8'h04;
  localparam logic [7:0]  ADDR_MODULE_ERR     = 8'h08;
  localparam logic [7:0]  ADDR_SETTING_NUM    = 8'h0c;
  localparam logic [7:0]  ADDR_PORT4_ERR      = 8'h10;
  localparam logic [7:0]  ADDR_PORT23_ERR     = 8'h14;
  localparam logic [7:0]  ADDR_EXP_MISMATCH   = 8'h18;
  localparam logic [7:0]  ADDR_MSG_STATUS     = 8'h1c;
  localparam logic [7:0]  ADDR_MSG_RESULT     = 8'h20;
  localparam logic [7:0]  ADDR_IRQ_STATUS     = 8'h24;
  localparam logic [7:0]  ADDR_IRQ_MASK       = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          MSG_READY_BIT       = 0;
  localparam int          MSG_RESULT_BIT      = 1;
  localparam int          IRQ_W               = 8;
  localparam int          EV_MSG_DONE         = 0;
  localparam int          EV_SELF_DIAG        = 1;
  localparam int          EV_MODULE_IO        = 2;
  localparam int          EV_MODULE           = 3;
  localparam int          EV_SETTING          = 4;
  localparam int          EV_PORT4            = 5;
  localparam int          EV_PORT23           = 6;
  localparam int          EV_EXPANSION        = 7;
  localparam logic [15:0] RST_WORD            = 16'h0000;
  localparam logic [7:0]  RST_IRQ             = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SEB_IDLE = 1'b0,
    SEB_BUSY = 1'b1
  } seb_op_t;

  // Event inputs from the controller core, one-cycle pulses with data
  typedef struct packed {
    logic        opStart;
    logic        opEnd;
    logic        opError;
    logic [15:0] opErrCode;
    logic        diagValid;
    logic [15:0] diagCode;
    logic [1:0]  moduleIoErr;
    logic [1:0]  moduleErr;
    logic        settingValid;
    logic [15:0] settingNum;
    logic [15:0] port4Err;
    logic [5:0]  port23Err;
  } seb_evt_t;

  typedef struct packed {
    seb_op_t     op;
    logic        resultFlag;
    logic [15:0] resultCode;
    logic [15:0] selfDiagCode;
    logic [15:0] moduleIoErr;
    logic [15:0] moduleErr;
    logic [15:0] settingNum;
    logic [15:0] port4Err;
    logic [15:0] port23Err;
    logic [15:0] expBaseline;
    logic        baselineValid;
    logic [15:0] expMismatch;
    logic [7:0]  irqStatus;
    logic [7:0]  irqMask;
    logic [31:0] prdata;
  } seb_state_t;

endpackage : seb_pkg

// ==== verification/seb_status_bank_tb.sv ====
// Self-checking bench for the status and error register bank.
// Assumes seb_pkg and seb_status_bank are compiled first; APB is zero wait.
module seb_status_bank_tb
  import seb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              ref_clk;
  logic              rst_n;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  seb_evt_t          evt;
  logic [15:0]       expInstalled;
  logic              msgReady;
  logic              irq;
  logic [31:0]       expWord [0:8];
  int                badCount;
  int                nChecks;
  int                cycles;

  seb_status_bank DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .evt(evt), .expInstalled(expInstalled), .msgReady(msgReady), .irq(irq));

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Whole run is well under 1000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic final_report;
    if (badCount == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk1(e, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic experr = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk32(r, exp);
    chk1(e, experr);
  endtask

  // One-cycle event, then settle to the following falling edge
  task automatic pulse(input seb_evt_t e);
    @(posedge ref_clk);
    evt <= e;
    @(posedge ref_clk);
    evt <= '0;
    @(negedge ref_clk);
  endtask

  task automatic check_all;
    for (int i = 0; i < 9; i++) rd(8'(i * 4), expWord[i]);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 9; i++) expWord[i] = 32'h0000_0000;
    expWord[7] = 32'h0000_0001;
    check_all();
    rd(8'h2c, 32'h0000_0000, 1'b1);
  endtask

  task automatic t_msg;
    seb_evt_t e;
    e = '0;
    e.opStart = 1'b1;
    pulse(e);
    chk1(msgReady, 1'b0);
    rd(ADDR_MSG_STATUS, 32'h0000_0000);
    e = '0;
    e.opEnd = 1'b1;
    e.opError = 1'b1;
    e.opErrCode = 16'h00a5;
    pulse(e);
    chk1(msgReady, 1'b1);
    rd(ADDR_MSG_STATUS, 32'h0000_0003);
    rd(ADDR_MSG_RESULT, 32'h0000_00a5);
    e = '0;
    e.opStart = 1'b1;
    pulse(e);
    e = '0;
    e.opEnd = 1'b1;
    pulse(e);
    rd(ADDR_MSG_STATUS, 32'h0000_0001);
    e = '0;
    e.opEnd = 1'b1;
    e.opError = 1'b1;
    e.opErrCode = 16'h0077;
    pulse(e);
    rd(ADDR_MSG_STATUS, 32'h0000_0001);
    rd(ADDR_MSG_RESULT, 32'h0000_00a5);
    e = '0;
    e.opStart = 1'b1;
    pulse(e);
    e.opEnd = 1'b1;
    pulse(e);
    chk1(msgReady, 1'b0);
    e = '0;
    e.opEnd = 1'b1;
    pulse(e);
    chk1(msgReady, 1'b1);
    rd(ADDR_MSG_STATUS, 32'h0000_0001);
    expWord[8] = 32'h0000_00a5;
  endtask

  // Second pulse checks code overwrite and sticky bitmaps
  task automatic t_events;
    seb_evt_t e;
    e = '0;
    e.diagValid = 1'b1;
    e.diagCode = 16'h1234;
    e.moduleIoErr = 2'h2;
    e.moduleErr = 2'h1;
    e.settingValid = 1'b1;
    e.settingNum = 16'h0042;
    e.port4Err = 16'h8001;
    e.port23Err = 6'h24;
    pulse(e);
    e = '0;
    e.diagValid = 1'b1;
    e.diagCode = 16'h00ff;
    e.moduleIoErr = 2'h1;
    e.port4Err = 16'h0100;
    e.port23Err = 6'h1b;
    pulse(e);
    expWord[0] = 32'h0000_00ff;
    expWord[1] = 32'h0000_0003;
    expWord[2] = 32'h0000_0001;
    expWord[3] = 32'h0000_0042;
    expWord[4] = 32'h0000_8101;
    expWord[5] = 32'h0000_003f;
    @(posedge ref_clk);
    expInstalled <= 16'h0005;
    repeat (2) @(posedge ref_clk);
    expWord[6] = 32'h0000_0005;
    check_all();
    rd(ADDR_IRQ_STATUS, 32'h0000_00ff);
  endtask

  task automatic t_readonly;
    for (int i = 0; i < 9; i++) wr(8'(i * 4), 32'hffff_ffff);
    check_all();
  endtask

  task automatic t_irq;
    seb_evt_t e;
    @(posedge ref_clk);
    expInstalled <= 16'h0000;
    repeat (2) @(posedge ref_clk);
    wr(ADDR_IRQ_STATUS, 32'h0000_00ff);
    rd(ADDR_IRQ_STATUS, 32'h0000_0000);
    e = '0;
    e.diagValid = 1'b1;
    e.diagCode = 16'h0007;
    pulse(e);
    rd(ADDR_IRQ_STATUS, 32'h0000_0002);
    chk1(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h0000_0002);
    @(negedge ref_clk);
    chk1(irq, 1'b1);
    rd(ADDR_IRQ_MASK, 32'h0000_0002);
    wr(ADDR_IRQ_STATUS, 32'h0000_0002);
    @(negedge ref_clk);
    chk1(irq, 1'b0);
    rd(ADDR_SELF_DIAG, 32'h0000_0007);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    evt = '0;
    expInstalled = 16'h0000;
    badCount = 0;
    nChecks = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_msg();
    t_events();
    t_readonly();
    t_irq();
    final_report();
  end

endmodule // seb_status_bank_tb
